/* rtl/rtc_wait_interval_seconds.sv */
// Purpose: RTC slice: freeze handshake, interval irq, divider pin, sub/sec/min
// Assumes: subclk_i is the 32.768 kHz pin, asynchronous to mclk_i
// Notes:   All subclock timing counts ticks of the synchronised subclock edge
// Functional notes
// - Alarm enable gates alarm match into interrupt
// - Wait bit freezes seconds and minutes counting
// - Wait status shows freeze actually in effect
// - Carry during freeze applied after release
// - Seconds write drops remembered carry
// - Status holds until buffered write completes
// - Interval interrupt only while enabled
// - Select picks 2^6..2^12 subclock period
// - Divider pin gated, 512 Hz or 16.384 kHz
// - Divider starts/stops within two subclocks
// - Backup mode kills interval and divider
// - Backup mode kills alarm interrupt
// - Read-only sub-second counter 0000H..7FFFH
// - Seconds write clears sub-second counter
// - Correction lets sub-second pass 7FFFH
// - BCD seconds 0..59, count on overflow
// - Counter writes buffered, land within two
// - Illegal seconds recover after one period
// - BCD minutes 0..59, count on seconds wrap
// - Power enable bit gates all counting
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"

module rtc_wait_interval_seconds
  import rtc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        subclk_i,
  input  wire logic        alarm_match_i,
  input  wire logic        backup_mode_i,
  input  wire logic        ecorr_active_i,
  input  wire logic [15:0] ecorr_top_i,
  output logic             alarm_interrupt_o,
  output logic             interval_interrupt_o,
  output logic             divider_output_pin_o,
  output logic             minute_carry_o,
  output logic             counter_enable_o
);

  logic [2:0]        subclk_sync_q;
  logic              tick;
  logic              wr_pend_q;
  logic [31:0]       wr_addr_q;
  logic              addr_ok;
  logic              wr_sec;
  logic              wr_min;
  logic              wr_cc2;
  logic              wr_cc3;
  logic              wr_pwr;
  logic              power_q;
  logic              alarm_en_q;
  logic              wait_ctl_q;
  interval_ctrl_type ictl_q;
  wait_state_type    wait_q;
  logic              frozen;
  logic              thaw;
  logic              counting;
  bcd_buf_type       sec_buf_q;
  bcd_buf_type       min_buf_q;
  logic [15:0]       subc_q;
  logic [15:0]       subc_d;
  logic [15:0]       subc_top;
  logic              subc_ovf;
  logic              carry_pend_q;
  logic              sec_step;
  logic [7:0]        sec_q;
  logic [7:0]        min_q;
  logic              sec_wrap;
  logic [3:0]        int_shift;
  logic [15:0]       int_mask;
  logic [31:0]       rdata;

  // Subclock pin: two flops, then a third for the edge
  // Nothing but the second stage reads the first; the third only holds history
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      subclk_sync_q <= 3'h0;
    end else begin
      subclk_sync_q <= {subclk_sync_q[1:0], subclk_i};
    end
  end
  assign tick = subclk_sync_q[1] & ~subclk_sync_q[2];

  // Bus address phase; only whole-word NONSEQ accesses count
  // Narrow or sequential beats are dropped, never stalled
  assign addr_ok = hsel_i & hready_i & (htrans_i == `RTC_HTRANS_NSEQ)
                   & (hsize_i == `RTC_HSIZE_WORD);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ok & hwrite_i;
      wr_addr_q <= haddr_i;
    end
  end

  // Data phase write strobes
  assign wr_sec = wr_pend_q & (wr_addr_q == `RTC_BYTE_ADDR(`RTC_IDX_SEC));
  assign wr_min = wr_pend_q & (wr_addr_q == `RTC_BYTE_ADDR(`RTC_IDX_MIN));
  assign wr_cc2 = wr_pend_q & (wr_addr_q == `RTC_BYTE_ADDR(`RTC_IDX_CC2));
  assign wr_cc3 = wr_pend_q & (wr_addr_q == `RTC_BYTE_ADDR(`RTC_IDX_CC3));
  assign wr_pwr = wr_pend_q & (wr_addr_q == `RTC_BYTE_ADDR(`RTC_IDX_PWR));

  // Read mux; unmapped words read zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (haddr_i)
      `RTC_BYTE_ADDR(`RTC_IDX_SUBC): rdata[15:0] = subc_q;
      `RTC_BYTE_ADDR(`RTC_IDX_SEC):  rdata[7:0]  = sec_q;
      `RTC_BYTE_ADDR(`RTC_IDX_MIN):  rdata[7:0]  = min_q;
      `RTC_BYTE_ADDR(`RTC_IDX_PWR):  rdata[`RTC_PWR_BIT] = power_q;
      `RTC_BYTE_ADDR(`RTC_IDX_CC2): begin
        rdata[`RTC_ALM_EN_BIT] = alarm_en_q;
        rdata[`RTC_WST_BIT]    = frozen;
        rdata[`RTC_WCTL_BIT]   = wait_ctl_q;
      end
      `RTC_BYTE_ADDR(`RTC_IDX_CC3): rdata[7:0] = {ictl_q.int_en, ictl_q.div_oe,
                                                  ictl_q.div_fsel, 2'h0,
                                                  ictl_q.int_sel};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Read data captured at the address phase, valid in the data phase
  // Zero wait states: a read adjacent to a write of the same word sees old data
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end else begin
      hrdata_o    <= (addr_ok & ~hwrite_i) ? rdata : 32'h0000_0000;
      hreadyout_o <= 1'b1;                     // Zero wait states, always OKAY
      hresp_o     <= 1'b0;
    end
  end

  // Control registers, all clear at reset
  // Only the defined control bits are kept; the rest of the word is ignored
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      power_q    <= 1'b0;
      alarm_en_q <= 1'b0;
      wait_ctl_q <= 1'b0;
      ictl_q     <= interval_ctrl_type'(`RTC_RST_BYTE);
    end else begin
      if (wr_pwr) begin
        power_q <= hwdata_i[`RTC_PWR_BIT];
      end
      if (wr_cc2) begin
        alarm_en_q <= hwdata_i[`RTC_ALM_EN_BIT];
        wait_ctl_q <= hwdata_i[`RTC_WCTL_BIT];
      end
      if (wr_cc3) begin
        ictl_q     <= interval_ctrl_type'(hwdata_i[7:0]);
        ictl_q.rsv <= 2'h0;                    // Reserved bits stay zero
      end
    end
  end

  // Freeze handshake, stepping on subclock edges only
  // The freeze takes hold only at a subclock edge, hence the status poll
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wait_q <= WAIT_RUN;
    end else if (tick) begin
      case (wait_q)
        WAIT_RUN: begin
          if (wait_ctl_q) begin
            wait_q <= WAIT_FROZEN;
          end
        end
        WAIT_FROZEN: begin
          if (!wait_ctl_q) begin
            wait_q <= WAIT_DRAIN;
          end
        end
        WAIT_DRAIN: begin
          // Status holds while a buffered write is still in flight
          if (wait_ctl_q) begin
            wait_q <= WAIT_FROZEN;
          end else if (!sec_buf_q.pend && !min_buf_q.pend) begin
            wait_q <= WAIT_RUN;
          end
        end
        default: wait_q <= WAIT_RUN;
      endcase
    end
  end
  assign frozen = (wait_q != WAIT_RUN);

  // Counting resumes on the edge that ends the drain, so a held carry
  // lands no later than the second subclock edge after the release
  assign thaw     = (wait_q == WAIT_DRAIN) & ~wait_ctl_q & ~sec_buf_q.pend
                    & ~min_buf_q.pend;
  assign counting = ~frozen | thaw;

  // Write buffers; transferred on the next subclock edge
  // A bus write beats the clearing tick, so it waits for the next one
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sec_buf_q <= '0;
      min_buf_q <= '0;
    end else begin
      if (wr_sec) begin
        sec_buf_q <= '{pend: 1'b1, data: hwdata_i[7:0]};
      end else if (tick) begin
        sec_buf_q.pend <= 1'b0;
      end
      if (wr_min) begin
        min_buf_q <= '{pend: 1'b1, data: hwdata_i[7:0]};
      end else if (tick) begin
        min_buf_q.pend <= 1'b0;
      end
    end
  end

  // Sub-second counter; correction may lift its top above 7FFFH
  // Limitation: a read while counting may catch a value in motion
  assign subc_top = ecorr_active_i ? ecorr_top_i : `RTC_SUBC_TOP;
  assign subc_ovf = tick & power_q & (subc_q >= subc_top);
  assign subc_d   = subc_ovf ? `RTC_RST_SUBC : subc_q + 16'h0001;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      subc_q <= `RTC_RST_SUBC;
    end else if (tick && sec_buf_q.pend) begin
      subc_q <= `RTC_RST_SUBC;
    end else if (tick && power_q) begin
      subc_q <= subc_d;
    end
  end

  // Carry taken while frozen is remembered; a seconds write drops it
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      carry_pend_q <= 1'b0;
    end else if (wr_sec) begin
      carry_pend_q <= 1'b0;
    end else if (subc_ovf && !counting) begin
      carry_pend_q <= 1'b1;
    end else if (tick && counting) begin
      carry_pend_q <= 1'b0;
    end
  end

  // A pending carry lands on the edge that ends the drain
  assign sec_step = tick & power_q & counting & (subc_ovf | carry_pend_q);
  // At or above 59 wraps, so an illegal load recovers in one period
  assign sec_wrap = sec_step & (sec_q >= `RTC_BCD_MAX);

  // Seconds register; a buffered load beats counting on the same edge
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sec_q <= `RTC_RST_BYTE;
    end else if (tick && sec_buf_q.pend) begin
      sec_q <= sec_buf_q.data;
    end else if (sec_wrap) begin
      sec_q <= `RTC_RST_BYTE;
    end else if (sec_step) begin
      if (sec_q[3:0] >= `RTC_BCD_NINE) begin
        sec_q <= {sec_q[7:4] + 4'h1, 4'h0};
      end else begin
        sec_q <= {sec_q[7:4], sec_q[3:0] + 4'h1};
      end
    end
  end

  // Minutes advance on the seconds wrap; carry out to the hour counter
  // A buffered load beats the seconds wrap on the same edge
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      min_q          <= `RTC_RST_BYTE;
      minute_carry_o <= 1'b0;
    end else begin
      minute_carry_o <= sec_wrap & ~(tick & min_buf_q.pend)
                        & (min_q >= `RTC_BCD_MAX);
      if (tick && min_buf_q.pend) begin
        min_q <= min_buf_q.data;
      end else if (sec_wrap) begin
        if (min_q >= `RTC_BCD_MAX) begin
          min_q <= `RTC_RST_BYTE;
        end else if (min_q[3:0] >= `RTC_BCD_NINE) begin
          min_q <= {min_q[7:4] + 4'h1, 4'h0};
        end else begin
          min_q <= {min_q[7:4], min_q[3:0] + 4'h1};
        end
      end
    end
  end

  // Interval period: codes 6 and 7 both give 2^12
  // Mask picks the low bits of the next sub-second value
  assign int_shift = `RTC_INT_BASE + {1'b0, (ictl_q.int_sel > `RTC_INT_SEL_MAX)
                                             ? `RTC_INT_SEL_MAX : ictl_q.int_sel};
  assign int_mask  = 16'((17'h1_0000 >> (5'd16 - {1'b0, int_shift})) - 17'h1);

  // Interval is one mclk pulse, alarm as wide as the match, both dead in backup; counter enable follows power
  // Gating sits before the flop, so no pulse starts once backup is seen
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      alarm_interrupt_o    <= 1'b0;
      interval_interrupt_o <= 1'b0;
      counter_enable_o     <= 1'b0;
    end else begin
      alarm_interrupt_o    <= alarm_match_i & alarm_en_q & ~backup_mode_i;
      interval_interrupt_o <= tick & power_q & ictl_q.int_en & ~backup_mode_i
                              & ((subc_d & int_mask) == 16'h0000);
      counter_enable_o     <= power_q;
    end
  end

  // Divider pin follows a sub-second bit; low when off or in backup
  // The fast rate toggles on every tick, half the subclock rate
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      divider_output_pin_o <= 1'b0;
    end else if (!ictl_q.div_oe || backup_mode_i) begin
      divider_output_pin_o <= 1'b0;
    end else begin
      divider_output_pin_o <= ictl_q.div_fsel ? subc_q[`RTC_DIV_FAST_BIT]
                                              : subc_q[`RTC_DIV_SLOW_BIT];
    end
  end

endmodule

`default_nettype wire

/* inc/rtc_cfg.svh */
// Purpose: Offsets, field positions, reset values and counts of the RTC slice
// Assumes: 32-bit AHB-Lite words, one register per aligned word
// Notes:   Byte address of a register is four times its index
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// Register indices; byte address = index * 4
`define RTC_IDX_SUBC      28'hFFFFAD0
`define RTC_IDX_SEC       28'hFFFFAD1
`define RTC_IDX_MIN       28'hFFFFAD3
`define RTC_IDX_PWR       28'hFFFFADD
`define RTC_IDX_CC2       28'hFFFFADF
`define RTC_IDX_CC3       28'hFFFFAE0
`define RTC_BYTE_ADDR(i)  {2'h0, (i), 2'h0}

// Field positions
`define RTC_PWR_BIT       7
`define RTC_ALM_EN_BIT    7
`define RTC_WST_BIT       1
`define RTC_WCTL_BIT      0

// Reset values
`define RTC_RST_BYTE      8'h00
`define RTC_RST_SUBC      16'h0000

// Counting constants
`define RTC_SUBC_TOP      16'h7FFF
`define RTC_BCD_MAX       8'h59
`define RTC_BCD_NINE      4'h9
`define RTC_INT_BASE      4'h6
`define RTC_INT_SEL_MAX   3'h6
`define RTC_DIV_SLOW_BIT  5
`define RTC_DIV_FAST_BIT  0
`define RTC_SUBCLK_HZ     32768
`define RTC_WR_DELAY_TCK  2
`define RTC_HTRANS_NSEQ   2'h2
`define RTC_HSIZE_WORD    3'h2

`endif

/* inc/rtc_pkg.sv */
// Purpose: Types shared by the RTC slice
// Assumes: rtc_cfg.svh on the include path
// Notes:   Field packing of the interval control register
package rtc_pkg;
  `include "rtc_cfg.svh"

  // Interval and divider control layout
  typedef struct packed {
    logic       int_en;
    logic       div_oe;
    logic       div_fsel;
    logic [1:0] rsv;
    logic [2:0] int_sel;
  } interval_ctrl_type;

  // Freeze handshake, Gray along run -> frozen -> drain
  typedef enum logic [1:0] {
    WAIT_RUN    = 2'b00,
    WAIT_FROZEN = 2'b01,
    WAIT_DRAIN  = 2'b11
  } wait_state_type;

  // Buffered counter write
  typedef struct packed {
    logic       pend;
    logic [7:0] data;
  } bcd_buf_type;
endpackage

/* tb/rtc_wis_props.sv */
// Purpose: Port-level checks of the RTC slice
// Assumes: Bound to the design top, one bus slave so hready_i follows hreadyout_o
// Notes:   Exact subclock counts are left to the bench
`timescale 1ns/1ps
`default_nettype none
module rtc_wis_props (
  input wire logic        mclk_i,
  input wire logic        srst_i,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        alarm_match_i,
  input wire logic        backup_mode_i,
  input wire logic        alarm_interrupt_o,
  input wire logic        interval_interrupt_o,
  input wire logic        divider_output_pin_o,
  input wire logic        minute_carry_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // Backup must have reached the output registers before suppression is owed
  sequence bk2_s;
    backup_mode_i [*2];
  endsequence
  sequence bk3_s;
    backup_mode_i [*3];
  endsequence
  // Alarm output only one cycle after a match, and never in the cycle after backup
  alm_gate_a: assert property (alarm_interrupt_o |-> $past(alarm_match_i))
    else $error("alarm raised without a match");
  bkup_alarm_a: assert property (backup_mode_i |=> !alarm_interrupt_o)
    else $error("alarm raised in backup mode");
  bkup_int_a: assert property (bk2_s |=> !interval_interrupt_o)
    else $error("interval pulse in backup mode");
  bkup_div_a: assert property (bk3_s |-> !divider_output_pin_o)
    else $error("divider pin active in backup mode");
  // Pulses are one cycle wide; real periods are far longer than eight cycles
  irq_pulse_a: assert property (interval_interrupt_o |=> !interval_interrupt_o [*8])
    else $error("interval pulse too wide");
  carry_pulse_a: assert property (minute_carry_o |=> !minute_carry_o [*8])
    else $error("minute carry too wide");
  // Read data only in the data phase of a read
  rd_idle_a: assert property (hrdata_o != 32'h0 |->
    $past(hsel_i && hready_i && htrans_i == 2'h2 && !hwrite_i))
    else $error("read data outside a read data phase");
  ready_okay_a: assert property (!$past(srst_i) |-> hreadyout_o && !hresp_o)
    else $error("slave stalled or answered an error");
endmodule

bind rtc_wait_interval_seconds rtc_wis_props u_props (.mclk_i, .srst_i, .hsel_i, .htrans_i,
  .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .alarm_match_i, .backup_mode_i,
  .alarm_interrupt_o, .interval_interrupt_o, .divider_output_pin_o, .minute_carry_o);
`default_nettype wire

/* tb/test_rtc_wait_interval_seconds.sv */
// Purpose: Self-checking bench of the RTC slice
// Assumes: Bench drives the subclock pin itself, four mclk cycles per tick
// Notes:   Short seconds come from the correction top value to keep the run brief
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"
module test_rtc_wait_interval_seconds;
  localparam logic [31:0] sub_adr = `RTC_BYTE_ADDR(`RTC_IDX_SUBC);
  localparam logic [31:0] sec_adr = `RTC_BYTE_ADDR(`RTC_IDX_SEC);
  localparam logic [31:0] min_adr = `RTC_BYTE_ADDR(`RTC_IDX_MIN);
  localparam logic [31:0] pwr_adr = `RTC_BYTE_ADDR(`RTC_IDX_PWR);
  localparam logic [31:0] cc2_adr = `RTC_BYTE_ADDR(`RTC_IDX_CC2);
  localparam logic [31:0] cc3_adr = `RTC_BYTE_ADDR(`RTC_IDX_CC3);
  localparam logic [31:0] bad_adr = 32'h3FFFEB48;
  logic        mclk_i = 0, srst_i = 1, hsel_i = 0, hwrite_i = 0, subclk_i = 0, pin_q = 0;
  logic        alarm_match_i = 0, backup_mode_i = 0, ecorr_active_i = 0;
  logic [1:0]  htrans_i = 2'h0;
  logic [2:0]  hsize_i = 3'h0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, r = 32'h256A2F5C, v;
  logic [15:0] ecorr_top_i = 16'h003F;
  wire  [31:0] hrdata_o;
  wire         hreadyout_o, hresp_o, alarm_interrupt_o, interval_interrupt_o;
  wire         divider_output_pin_o, minute_carry_o, counter_enable_o;
  wire         hready_i = hreadyout_o;
  int          n_errors = 0, n_checks = 0, n_irq = 0, n_div = 0, n_car = 0, cyc = 0;

  rtc_wait_interval_seconds u_dut (.mclk_i, .srst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .subclk_i,
    .alarm_match_i, .backup_mode_i, .ecorr_active_i, .ecorr_top_i, .alarm_interrupt_o,
    .interval_interrupt_o, .divider_output_pin_o, .minute_carry_o, .counter_enable_o);

  always #20 mclk_i = ~mclk_i;

  // Event counters; the main sequence reads differences, never clears them
  always @(posedge mclk_i) begin
    n_irq <= n_irq + interval_interrupt_o;
    n_div <= n_div + (divider_output_pin_o & !pin_q);
    n_car <= n_car + minute_carry_o;
    pin_q <= divider_output_pin_o;
    cyc   <= cyc + 1;
    if (cyc == 80000) begin
      n_errors++;
      $display("mismatch %0t timeout", $time);
      results();
    end
  end

  function logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // BCD step; anything at or past 59 wraps to zero
  function int inc(int x);
    return (x >= 8'h59) ? 0 : (x % 16 == 9) ? x + 7 : x + 1;
  endfunction

  task results;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask

  // One single word transfer; entered just after a rising edge
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel_i   <= 1;
    hwrite_i <= w;
    haddr_i  <= a;
    htrans_i <= 2'h2;
    hsize_i  <= 3'h2;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hsel_i   <= 0;
    hwdata_i <= d;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1, a, d, q);
  endtask

  task rc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(0, a, 32'h0, q);
    chk(q, e);
  endtask

  // Subclock ticks, then time for the synchroniser to drain
  task tk(input int n);
    repeat (n) begin
      subclk_i <= 1;
      repeat (2) @(posedge mclk_i);
      subclk_i <= 0;
      repeat (2) @(posedge mclk_i);
    end
    repeat (6) @(posedge mclk_i);
  endtask

  task poll(input logic b);
    logic [31:0] q;
    for (int i = 0; i < 8; i++) begin
      tk(1);
      bus(0, cc2_adr, 32'h0, q);
      if (q[1] === b)
        break;
    end
    chk(q[1], b);
  endtask

  initial begin
    logic [31:0] q;
    logic [31:0] ra [6] = '{sub_adr, sec_adr, min_adr, pwr_adr, cc2_adr, cc3_adr};
    int          c0, p, w, bi, bd;
    repeat (12) @(posedge mclk_i);
    srst_i <= 0;
    repeat (3) @(posedge mclk_i);
    // Reset values, read-only and unmapped places
    foreach (ra[i]) rc(ra[i], 32'h0);
    wr(sub_adr, 32'h1234);
    rc(sub_adr, 32'h0);
    wr(bad_adr, 32'hFF);
    rc(bad_adr, 32'h0);
    r = lfsr(r);
    wr(cc3_adr, r);
    rc(cc3_adr, r & 32'hE7);
    // Random alarm matches and backup, enable off then on
    for (int e = 0; e < 2; e++) begin
      wr(cc2_adr, e << 7);
      c0 = 0;
      repeat (100) begin
        @(posedge mclk_i);
        chk(alarm_interrupt_o, c0);
        c0 = alarm_match_i & e & !backup_mode_i;
        r = lfsr(r);
        alarm_match_i <= r[0];
        backup_mode_i <= r[1] & r[2];
      end
      @(posedge mclk_i);
      chk(alarm_interrupt_o, c0);
      alarm_match_i <= 0;
      backup_mode_i <= 0;
    end
    // Frozen writes, then two seconds of counting into the minute carry
    ecorr_active_i <= 1;
    wr(pwr_adr, 32'h80);
    repeat (2) @(posedge mclk_i);
    chk(counter_enable_o, 1);
    wr(cc2_adr, 32'h1);
    poll(1);
    wr(sec_adr, 32'h58);
    wr(min_adr, 32'h59);
    tk(4);
    rc(sec_adr, 32'h58);
    rc(min_adr, 32'h59);
    c0 = n_car;
    wr(cc2_adr, 32'h0);
    poll(0);
    tk(150);
    rc(sec_adr, inc(inc(8'h58)));
    rc(min_adr, inc(8'h59));
    chk(n_car - c0, 1);
    // Overflow during a freeze is kept, unless seconds are rewritten
    wr(cc2_adr, 32'h1);
    poll(1);
    wr(sec_adr, 32'h10);
    tk(80);
    rc(sec_adr, 32'h10);
    wr(cc2_adr, 32'h0);
    poll(0);
    rc(sec_adr, inc(8'h10));
    tk(20);
    wr(cc2_adr, 32'h1);
    poll(1);
    tk(70);
    wr(sec_adr, 32'h65);
    tk(2);
    bus(0, sub_adr, 32'h0, q);
    chk(q < 16, 1);
    wr(cc2_adr, 32'h0);
    poll(0);
    tk(20);
    rc(sec_adr, 32'h65);
    tk(48);
    rc(sec_adr, inc(8'h65));
    // Every interval code and both divider rates over whole periods
    ecorr_active_i <= 0;
    for (int i = 0; i < 9; i++) begin
      c0 = i % 8;
      p = 1 << (6 + (c0 > 6 ? 6 : c0));
      w = p < 1024 ? 1024 : p;
      v = {i < 8, c0[0], c0[1], 2'b0, c0[2:0]};
      wr(cc3_adr, v);
      rc(cc3_adr, v);
      repeat (4) @(posedge mclk_i);
      bi = n_irq;
      bd = n_div;
      tk(w);
      chk(n_irq - bi, v[7] ? w / p : 0);
      chk(n_div - bd, v[6] ? (v[5] ? w / 2 : w / 64) : 0);
    end
    // Backup mode silences interval pulse and divider pin
    wr(cc3_adr, 32'hE0);
    backup_mode_i <= 1;
    bi = n_irq;
    bd = n_div;
    tk(128);
    chk(n_irq - bi, 0);
    chk(n_div - bd, 0);
    backup_mode_i <= 0;
    results();
  end
endmodule
`default_nettype wire
